// *** rtl/gcf_top.sv ***
// Summary of operation
// - Pending-event word readable; each set bit is one pending event.
// - Writing one to event-clear clears the matching pending bit.
// - Scanout count reports maximum outputs, held between 1 and 16.
// - Display configuration change sets pending bit 0.
// - Config space is four 32-bit words: events, clear, count, reserved.
// - Unfenced control requests may be answered before processing ends.
// - Fenced request: echo flag and fence identifier, answer after completion.
// - Requests and responses carry type, flags, fence, context, padding.
// - Command codes run consecutively from 0x0100, 0x0200 and 0x0300.
// - Success answers 0x1100, or the payload-specific success code.
// - Failures answer consecutive error codes from 0x1200.
// - Cursor update sets shape and position; move changes position only.
// - Unaccelerated mode supports transfers only from guest into host.
// - Driver still issues transfers; device may copy instead of mapping.
// - Feature bit 1 is EDID, bit 2 shared resources; gate those commands.
// - Queue 0 carries control, queue 1 carries cursor updates.
module gcf_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    output logic [31:0] cfg_rdata,
    input wire logic display_change_pin,
    input wire logic [4:0] scanout_limit,
    input wire logic req_valid,
    input wire logic req_queue,
    input wire logic [31:0] req_type,
    input wire logic [31:0] req_flags,
    input wire logic [63:0] req_fence_identifier,
    input wire logic [31:0] req_render_context_id,
    output logic req_ready,
    input wire logic work_done,
    input wire logic work_error,
    input wire logic [2:0] work_error_sel,
    output logic work_start,
    output logic [31:0] work_type,
    output logic resp_valid,
    output logic resp_queue,
    output logic [31:0] resp_type,
    output logic [31:0] resp_flags,
    output logic [63:0] resp_fence_identifier,
    output logic [31:0] resp_render_context_id,
    output logic [31:0] resp_padding,
    output logic cursor_shape_load,
    output logic cursor_pos_load,
    output logic [31:0] feature_ctrl
);
    typedef enum logic [1:0] {GCF_IDLE, GCF_BUSY, GCF_ANSWER} gcf_state_t;

    // ------------------------------------------------------------
    // Error code selection
    // ------------------------------------------------------------
    function automatic logic [31:0] err_code(input logic [2:0] sel);
        logic [2:0] s;
        s = (sel > gcf_pkg::ERR_SEL_MAX) ? 3'h0 : sel;
        err_code = gcf_pkg::ERROR_UNSPECIFIED + {29'h0, s};
    endfunction

    gcf_state_t state_reg;
    logic [31:0] pending_reg;
    logic [31:0] feature_reg;
    logic [4:0] scanout_reg;
    logic chg_sync;
    logic chg_seen_reg;
    logic known;
    logic is_cursor_cmd;
    logic sets_shape;
    logic [31:0] ok_type;
    logic fence_reg;
    logic [31:0] ok_reg;
    logic display_event;

    // ------------------------------------------------------------
    // Display change detection
    // ------------------------------------------------------------
    gcf_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(display_change_pin),
        .sync_out(chg_sync)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chg_seen_reg <= 1'b0;
        end else begin
            chg_seen_reg <= chg_sync;
        end
    end

    assign display_event = chg_sync & ~chg_seen_reg;

    // ------------------------------------------------------------
    // Pending events: set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_reg <= gcf_pkg::PENDING_RESET;
        end else begin
            logic [31:0] pending_next;
            pending_next = pending_reg;
            if (cfg_wr && cfg_addr == gcf_pkg::ADDR_EVENT_CLEAR_STROBE) begin
                pending_next = pending_next & ~cfg_wdata;
            end
            if (display_event) begin
                pending_next[gcf_pkg::EVENT_DISPLAY_BIT] = 1'b1;
            end
            pending_reg <= pending_next;
        end
    end

    // ------------------------------------------------------------
    // Scanout count and feature control
    // ------------------------------------------------------------
    // Limit is a strap resampled on every clock after reset release, clamped to the legal range
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scanout_reg <= gcf_pkg::SCANOUT_DEFAULT;
        end else if (scanout_limit < gcf_pkg::SCANOUT_MIN) begin
            scanout_reg <= gcf_pkg::SCANOUT_MIN;
        end else if (scanout_limit > gcf_pkg::SCANOUT_MAX) begin
            scanout_reg <= gcf_pkg::SCANOUT_MAX;
        end else begin
            scanout_reg <= scanout_limit;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            feature_reg <= gcf_pkg::FEATURE_RESET;
        end else if (cfg_wr && cfg_addr == gcf_pkg::ADDR_FEATURE_CTRL) begin
            feature_reg <= cfg_wdata & 32'h0000_0006;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            feature_ctrl <= gcf_pkg::FEATURE_RESET;
        end else begin
            feature_ctrl <= feature_reg;
        end
    end

    // ------------------------------------------------------------
    // Configuration read port
    // ------------------------------------------------------------
    // Writes to the pending word and the scanout word fall through unused
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= 32'h0000_0000;
        end else if (cfg_rd) begin
            case (cfg_addr)
                gcf_pkg::ADDR_PENDING_EVENT_FLAGS: cfg_rdata <= pending_reg;
                gcf_pkg::ADDR_SCANOUT_COUNT: cfg_rdata <= {27'h0, scanout_reg};
                gcf_pkg::ADDR_FEATURE_CTRL: cfg_rdata <= feature_reg;
                default: cfg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            cfg_rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Request decoding
    // ------------------------------------------------------------
    gcf_decode u_decode (
        .cmd_type(req_type),
        .queue_sel(req_queue),
        .feat_edid(feature_reg[gcf_pkg::FEATURE_EDID_BIT]),
        .feat_shared(feature_reg[gcf_pkg::FEATURE_SHARED_BIT]),
        .known(known),
        .is_cursor_cmd(is_cursor_cmd),
        .sets_shape(sets_shape),
        .ok_type(ok_type)
    );

    // ------------------------------------------------------------
    // Command lifecycle
    // ------------------------------------------------------------
    // One request in flight; the driver holds req_valid until req_ready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= GCF_IDLE;
            req_ready <= 1'b1;
            work_start <= 1'b0;
            work_type <= 32'h0000_0000;
            resp_valid <= 1'b0;
            resp_queue <= 1'b0;
            resp_type <= 32'h0000_0000;
            resp_flags <= 32'h0000_0000;
            resp_fence_identifier <= 64'h0;
            resp_render_context_id <= 32'h0000_0000;
            resp_padding <= 32'h0000_0000;
            fence_reg <= 1'b0;
            ok_reg <= 32'h0000_0000;
            cursor_shape_load <= 1'b0;
            cursor_pos_load <= 1'b0;
        end else begin
            work_start <= 1'b0;
            resp_valid <= 1'b0;
            cursor_shape_load <= 1'b0;
            cursor_pos_load <= 1'b0;
            case (state_reg)
                GCF_IDLE: begin
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        resp_queue <= req_queue;
                        resp_fence_identifier <= 64'h0;
                        resp_flags <= 32'h0000_0000;
                        resp_render_context_id <= req_render_context_id;
                        resp_padding <= 32'h0000_0000;
                        fence_reg <= req_flags[gcf_pkg::FLAG_FENCE_BIT];
                        ok_reg <= ok_type;
                        if (req_flags[gcf_pkg::FLAG_FENCE_BIT]) begin
                            resp_flags[gcf_pkg::FLAG_FENCE_BIT] <= 1'b1;
                            resp_fence_identifier <= req_fence_identifier;
                        end
                        if (!known) begin
                            resp_type <= gcf_pkg::ERROR_UNSPECIFIED;
                            state_reg <= GCF_ANSWER;
                        end else if (is_cursor_cmd) begin
                            cursor_shape_load <= sets_shape;
                            cursor_pos_load <= 1'b1;
                            resp_type <= gcf_pkg::SUCCESS_NO_PAYLOAD;
                            state_reg <= GCF_ANSWER;
                        end else begin
                            work_start <= 1'b1;
                            work_type <= req_type;
                            if (!req_flags[gcf_pkg::FLAG_FENCE_BIT] && ok_type == gcf_pkg::SUCCESS_NO_PAYLOAD) begin
                                // Early answer trades error visibility for latency
                                resp_type <= gcf_pkg::SUCCESS_NO_PAYLOAD;
                                resp_valid <= 1'b1;
                            end
                            state_reg <= GCF_BUSY;
                        end
                    end
                end
                GCF_BUSY: begin
                    if (work_done) begin
                        if (fence_reg || ok_reg != gcf_pkg::SUCCESS_NO_PAYLOAD) begin
                            resp_type <= work_error ? err_code(work_error_sel) : ok_reg;
                            state_reg <= GCF_ANSWER;
                        end else begin
                            req_ready <= 1'b1;
                            state_reg <= GCF_IDLE;
                        end
                    end
                end
                GCF_ANSWER: begin
                    resp_valid <= 1'b1;
                    req_ready <= 1'b1;
                    state_reg <= GCF_IDLE;
                end
                default: begin
                    state_reg <= GCF_IDLE;
                    req_ready <= 1'b1;
                end
            endcase
        end
    end
endmodule

// *** rtl/gcf_pkg.sv ***
package gcf_pkg;
    // ------------------------------------------------------------
    // Configuration byte addresses (word index = address / 4, except feature control at 0x2)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_PENDING_EVENT_FLAGS = 4'h0;
    localparam logic [3:0] ADDR_EVENT_CLEAR_STROBE = 4'h4;
    localparam logic [3:0] ADDR_SCANOUT_COUNT = 4'h8;
    localparam logic [3:0] ADDR_RESERVED_WORD = 4'hc;
    localparam logic [3:0] ADDR_FEATURE_CTRL = 4'h2;
    localparam int EVENT_DISPLAY_BIT = 0;
    localparam int FEATURE_EDID_BIT = 1;
    localparam int FEATURE_SHARED_BIT = 2;
    localparam int FLAG_FENCE_BIT = 0;
    localparam logic [31:0] PENDING_RESET = 32'h0000_0000;
    localparam logic [31:0] FEATURE_RESET = 32'h0000_0000;
    localparam logic [4:0] SCANOUT_MIN = 5'h01;
    localparam logic [4:0] SCANOUT_MAX = 5'h10;
    localparam logic [4:0] SCANOUT_DEFAULT = 5'h01;
    localparam int QUEUE_CONTROL = 0;
    localparam int QUEUE_CURSOR = 1;
    // ------------------------------------------------------------
    // Header type codes
    // ------------------------------------------------------------
    localparam logic [31:0] CMD_BASE_2D = 32'h0000_0100;
    localparam logic [31:0] CMD_BASE_3D = 32'h0000_0200;
    localparam logic [31:0] CMD_BASE_CURSOR = 32'h0000_0300;
    localparam logic [31:0] CMD_DISPLAY_INFO = 32'h0000_0100;
    localparam logic [31:0] CMD_CREATE_2D = 32'h0000_0101;
    localparam logic [31:0] CMD_UNREF = 32'h0000_0102;
    localparam logic [31:0] CMD_SET_SCANOUT = 32'h0000_0103;
    localparam logic [31:0] CMD_FLUSH = 32'h0000_0104;
    localparam logic [31:0] CMD_TRANSFER_TO_HOST = 32'h0000_0105;
    localparam logic [31:0] CMD_ATTACH_BACKING = 32'h0000_0106;
    localparam logic [31:0] CMD_DETACH_BACKING = 32'h0000_0107;
    localparam logic [31:0] CMD_CAPSET_INFO = 32'h0000_0108;
    localparam logic [31:0] CMD_CAPSET = 32'h0000_0109;
    localparam logic [31:0] CMD_EDID = 32'h0000_010a;
    localparam logic [31:0] CMD_CREATE_2D_SHARED = 32'h0000_010b;
    localparam logic [31:0] CMD_3D_LAST = 32'h0000_0208;
    localparam logic [31:0] CMD_UPDATE_CURSOR = 32'h0000_0300;
    localparam logic [31:0] CMD_MOVE_CURSOR = 32'h0000_0301;
    localparam logic [31:0] SUCCESS_NO_PAYLOAD = 32'h0000_1100;
    localparam logic [31:0] OK_DISPLAY_INFO = 32'h0000_1101;
    localparam logic [31:0] OK_CAPSET_INFO = 32'h0000_1102;
    localparam logic [31:0] OK_CAPSET = 32'h0000_1103;
    localparam logic [31:0] OK_EDID = 32'h0000_1104;
    localparam logic [31:0] ERROR_UNSPECIFIED = 32'h0000_1200;
    localparam logic [31:0] ERR_OUT_OF_MEMORY = 32'h0000_1201;
    localparam logic [31:0] ERR_INVALID_SCANOUT = 32'h0000_1202;
    localparam logic [31:0] ERR_INVALID_RESOURCE = 32'h0000_1203;
    localparam logic [31:0] ERR_INVALID_CONTEXT = 32'h0000_1204;
    localparam logic [31:0] ERR_INVALID_PARAMETER = 32'h0000_1205;
    localparam logic [31:0] ERR_NO_BACKING = 32'h0000_1206;
    localparam logic [2:0] ERR_SEL_MAX = 3'h6;
endpackage

// *** rtl/gcf_decode.sv ***
module gcf_decode (
    input wire logic [31:0] cmd_type,
    input wire logic queue_sel,
    input wire logic feat_edid,
    input wire logic feat_shared,
    output logic known,
    output logic is_cursor_cmd,
    output logic sets_shape,
    output logic [31:0] ok_type
);
    // ------------------------------------------------------------
    // Command classification
    // ------------------------------------------------------------
    always_comb begin
        known = 1'b0;
        is_cursor_cmd = 1'b0;
        sets_shape = 1'b0;
        ok_type = gcf_pkg::SUCCESS_NO_PAYLOAD;
        if (queue_sel == 1'(gcf_pkg::QUEUE_CURSOR)) begin
            if (cmd_type == gcf_pkg::CMD_UPDATE_CURSOR) begin
                known = 1'b1;
                is_cursor_cmd = 1'b1;
                sets_shape = 1'b1;
            end else if (cmd_type == gcf_pkg::CMD_MOVE_CURSOR) begin
                known = 1'b1;
                is_cursor_cmd = 1'b1;
            end
        end else begin
            if (cmd_type >= gcf_pkg::CMD_BASE_2D && cmd_type <= gcf_pkg::CMD_CREATE_2D_SHARED) begin
                known = 1'b1;
            end
            // 3D group is not decoded and is answered as unknown: this device is unaccelerated
            if (cmd_type == gcf_pkg::CMD_EDID && !feat_edid) begin
                known = 1'b0;
            end
            if (cmd_type == gcf_pkg::CMD_CREATE_2D_SHARED && !feat_shared) begin
                known = 1'b0;
            end
            case (cmd_type)
                gcf_pkg::CMD_DISPLAY_INFO: ok_type = gcf_pkg::OK_DISPLAY_INFO;
                gcf_pkg::CMD_CAPSET_INFO: ok_type = gcf_pkg::OK_CAPSET_INFO;
                gcf_pkg::CMD_CAPSET: ok_type = gcf_pkg::OK_CAPSET;
                gcf_pkg::CMD_EDID: ok_type = gcf_pkg::OK_EDID;
                default: ok_type = gcf_pkg::SUCCESS_NO_PAYLOAD;
            endcase
        end
    end
endmodule

// *** rtl/gcf_sync.sv ***
module gcf_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;
    // Two stages; the first is read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// *** tb/gcf_backend_model.sv ***
module gcf_backend_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic work_start,
    input wire logic [7:0] delay,
    input wire logic err_en,
    input wire logic [2:0] err_sel,
    output logic work_done,
    output logic work_error,
    output logic [2:0] work_error_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Processing engine with a settable latency
    // ------------------------------------------------------------
    logic [7:0] cnt_reg;
    logic busy_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            busy_reg <= 1'b0;
            work_done <= 1'b0;
            work_error <= 1'b0;
            work_error_sel <= 3'h0;
        end else begin
            work_done <= 1'b0;
            // Status is only meaningful with done, so it churns otherwise
            work_error <= ~work_error;
            work_error_sel <= work_error_sel + 3'h1;
            if (work_start) begin
                busy_reg <= 1'b1;
                cnt_reg <= delay;
            end else if (busy_reg && cnt_reg == 8'h00) begin
                busy_reg <= 1'b0;
                work_done <= 1'b1;
                work_error <= err_en;
                work_error_sel <= err_sel;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule

// *** tb/gcf_chk.sv ***
module gcf_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] cfg_addr,
    input wire logic cfg_rd,
    input wire logic [31:0] cfg_rdata,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_queue,
    input wire logic [31:0] req_type,
    input wire logic [31:0] req_flags,
    input wire logic [63:0] req_fence_identifier,
    input wire logic work_done,
    input wire logic resp_valid,
    input wire logic resp_queue,
    input wire logic [31:0] resp_type,
    input wire logic [31:0] resp_flags,
    input wire logic [63:0] resp_fence_identifier,
    input wire logic [31:0] resp_padding,
    input wire logic cursor_shape_load,
    input wire logic cursor_pos_load
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Header captured when a request is taken
    // ------------------------------------------------------------
    logic [31:0] typ_reg;
    logic [63:0] fid_reg;
    logic fen_reg;
    logic q_reg;
    logic tk;
    logic ctl;
    logic unk;
    assign tk = req_valid && req_ready;
    assign ctl = !q_reg && typ_reg >= gcf_pkg::CMD_DISPLAY_INFO && typ_reg <= gcf_pkg::CMD_CAPSET;
    assign unk = !(typ_reg >= gcf_pkg::CMD_DISPLAY_INFO && typ_reg <= gcf_pkg::CMD_CREATE_2D_SHARED)
        && typ_reg != gcf_pkg::CMD_UPDATE_CURSOR && typ_reg != gcf_pkg::CMD_MOVE_CURSOR;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            typ_reg <= 32'h0;
            fid_reg <= 64'h0;
            fen_reg <= 1'b0;
            q_reg <= 1'b0;
        end else if (tk) begin
            typ_reg <= req_type;
            fid_reg <= req_fence_identifier;
            fen_reg <= req_flags[0];
            q_reg <= req_queue;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    rdata_idle_a: assert property (!$past(cfg_rd) |-> cfg_rdata == 32'h0)
        else $error("read data not zero outside its slot");
    rsvd_zero_a: assert property (cfg_rd && cfg_addr == gcf_pkg::ADDR_RESERVED_WORD |=> cfg_rdata == 32'h0)
        else $error("reserved word not zero");
    scan_range_a: assert property (cfg_rd && cfg_addr == gcf_pkg::ADDR_SCANOUT_COUNT |=>
        cfg_rdata inside {[32'h1:32'h10]})
        else $error("scanout count out of range");
    fence_echo_a: assert property (resp_valid && fen_reg |-> resp_flags[0] && resp_fence_identifier == fid_reg)
        else $error("fence not echoed");
    fence_late_a: assert property (resp_valid && fen_reg && ctl |-> $past(work_done, 2))
        else $error("fenced answer not tied to completion");
    pad_zero_a: assert property (resp_padding == 32'h0)
        else $error("response padding not zero");
    take_busy_a: assert property (tk |=> !req_ready)
        else $error("ready stayed high after take");
    take_answer_a: assert property (tk |-> ##[1:100] resp_valid)
        else $error("request never answered");
    unknown_err_a: assert property (resp_valid && unk |-> resp_type == gcf_pkg::ERROR_UNSPECIFIED)
        else $error("unknown type not answered with error");
    queue_echo_a: assert property (resp_valid |-> resp_queue == q_reg)
        else $error("answer on wrong queue");
    shape_pos_a: assert property (cursor_shape_load |-> cursor_pos_load && typ_reg == gcf_pkg::CMD_UPDATE_CURSOR)
        else $error("shape load without full update");
    fenced_c: cover property (resp_valid && fen_reg && ctl);
    shape_c: cover property (cursor_shape_load);
    unknown_c: cover property (resp_valid && unk);
endmodule
bind gcf_top gcf_chk gcf_chk_inst (.clk, .rst_n, .cfg_addr, .cfg_rd, .cfg_rdata, .req_valid, .req_ready, .req_queue,
    .req_type, .req_flags, .req_fence_identifier, .work_done, .resp_valid, .resp_queue, .resp_type, .resp_flags,
    .resp_fence_identifier, .resp_padding, .cursor_shape_load, .cursor_pos_load);

// *** tb/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic q; logic [31:0] t; logic f; logic [31:0] e;} gcf_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] cfg_addr = 4'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic cfg_wr = 1'b0, cfg_rd = 1'b0;
    logic display_change_pin = 1'b0;
    logic [4:0] scanout_limit = 5'h14;
    logic req_valid = 1'b0;
    logic req_queue = 1'b0;
    logic [31:0] req_type = 32'h0;
    logic [31:0] req_flags = 32'h0;
    logic [63:0] req_fence_identifier = 64'h0;
    logic [31:0] req_render_context_id = 32'h5;
    logic [7:0] dly = 8'h00;
    logic err_en = 1'b0;
    logic [2:0] err_sel = 3'h0;
    logic req_ready, work_done, work_error, work_start, resp_valid, resp_queue, cursor_shape_load, cursor_pos_load;
    logic [2:0] work_error_sel;
    logic [31:0] cfg_rdata, work_type, resp_type, resp_flags, resp_render_context_id, resp_padding, feature_ctrl;
    logic [63:0] resp_fence_identifier;
    int num_errors = 0, n_checks = 0, n_shape = 0, n_pos = 0, n_start = 0;
    gcf_row_t rows [20] = '{
        '{1'b0, 32'h100, 1'b0, 32'h1101}, '{1'b0, 32'h101, 1'b1, 32'h1100}, '{1'b0, 32'h102, 1'b0, 32'h1100},
        '{1'b0, 32'h103, 1'b1, 32'h1100}, '{1'b0, 32'h104, 1'b0, 32'h1100}, '{1'b0, 32'h105, 1'b1, 32'h1100},
        '{1'b0, 32'h106, 1'b0, 32'h1100}, '{1'b0, 32'h107, 1'b0, 32'h1100}, '{1'b0, 32'h108, 1'b1, 32'h1102},
        '{1'b0, 32'h109, 1'b0, 32'h1103}, '{1'b0, 32'h10a, 1'b1, 32'h1104}, '{1'b0, 32'h10b, 1'b0, 32'h1100},
        '{1'b0, 32'h200, 1'b1, 32'h1200}, '{1'b0, 32'h208, 1'b0, 32'h1200}, '{1'b1, 32'h300, 1'b0, 32'h1100},
        '{1'b1, 32'h301, 1'b1, 32'h1100}, '{1'b0, 32'h300, 1'b0, 32'h1200}, '{1'b1, 32'h104, 1'b0, 32'h1200},
        '{1'b0, 32'h10c, 1'b1, 32'h1200}, '{1'b0, 32'h099, 1'b0, 32'h1200}};
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (cursor_shape_load === 1'b1) n_shape++;
        if (cursor_pos_load === 1'b1) n_pos++;
        if (work_start === 1'b1) n_start++;
    end
    gcf_top gcf_top_inst (.clk, .rst_n, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata, .display_change_pin,
        .scanout_limit, .req_valid, .req_queue, .req_type, .req_flags, .req_fence_identifier, .req_render_context_id,
        .req_ready, .work_done, .work_error, .work_error_sel, .work_start, .work_type, .resp_valid, .resp_queue,
        .resp_type, .resp_flags, .resp_fence_identifier, .resp_render_context_id, .resp_padding, .cursor_shape_load,
        .cursor_pos_load, .feature_ctrl);
    gcf_backend_model gcf_backend_model_inst (.clk, .rst_n, .work_start, .delay(dly), .err_en, .err_sel,
        .work_done, .work_error, .work_error_sel);
    // ------------------------------------------------------------
    // Bus and request tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        cfg_addr <= a;
        cfg_rd <= 1'b1;
        @(posedge clk);
        cfg_rd <= 1'b0;
        #1;
        chk(64'(cfg_rdata), 64'(e));
    endtask
    task automatic req(input gcf_row_t r, input logic [63:0] fid);
        int k;
        k = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_queue <= r.q;
        req_type <= r.t;
        req_flags <= {31'h0, r.f};
        req_fence_identifier <= fid;
        do begin
            @(posedge clk);
            k++;
        end while (req_ready !== 1'b1 && k < 200);
        // Released type and fence identifier flip so a stale copy of them cannot pass
        req_valid <= 1'b0;
        req_type <= ~r.t;
        req_fence_identifier <= ~fid;
        #1;
        k = 0;
        while (resp_valid !== 1'b1 && k < 200) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(64'(resp_valid), 64'h1);
        chk(64'(resp_type), 64'(r.e));
        chk(64'(resp_queue), 64'(r.q));
        chk(64'(resp_padding), 64'h0);
        chk(64'(resp_render_context_id), 64'h5);
        if (!r.q && r.e != 32'h1200) chk(64'(work_type), 64'(r.t));
        if (r.f === 1'b1) begin
            chk(64'(resp_flags[0]), 64'h1);
            chk(resp_fence_identifier, fid);
        end
        k = 0;
        while (req_ready !== 1'b1 && k < 200) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        chk(64'(feature_ctrl), 64'h0);
        rd(4'h8, 32'h10);
        rd(4'hc, 32'h0);
        rd(4'h0, 32'h0);
        rd(4'h5, 32'h0);
        wr(4'h8, 32'h5);
        rd(4'h8, 32'h10);
        req('{1'b0, 32'h10a, 1'b0, 32'h1200}, 64'h1);
        req('{1'b0, 32'h10b, 1'b0, 32'h1200}, 64'h2);
        wr(gcf_pkg::ADDR_FEATURE_CTRL, 32'hffff_ffff);
        #101;
        chk(64'(feature_ctrl), 64'h6);
        $display("config and gating test done");
        for (int i = 0; i < 20; i++) begin
            req(rows[i], {32'(i), ~32'(i)});
        end
        chk(64'(n_shape), 64'h1);
        chk(64'(n_pos), 64'h2);
        chk(64'(n_start), 64'hc);
        $display("command table test done");
        // Slow backend so the fenced answer must wait for completion
        err_en <= 1'b1;
        dly <= 8'h28;
        for (int s = 0; s < 8; s++) begin
            err_sel <= 3'(s);
            req('{1'b0, 32'h104, 1'b1, (s > 6) ? 32'h1200 : 32'h1200 + 32'(s)}, 64'h0123_4567_89ab_cdef);
        end
        err_en <= 1'b0;
        dly <= 8'h00;
        $display("error code test done");
        @(posedge clk);
        display_change_pin <= 1'b1;
        repeat (5) @(posedge clk);
        rd(4'h0, 32'h1);
        req('{1'b0, 32'h100, 1'b0, 32'h1101}, 64'h3);
        wr(4'h4, 32'h0);
        rd(4'h0, 32'h1);
        wr(4'h0, 32'h6);
        rd(4'h0, 32'h1);
        wr(4'h4, 32'h1);
        rd(4'h0, 32'h0);
        display_change_pin <= 1'b0;
        $display("event test done");
        @(posedge clk);
        scanout_limit <= 5'h00;
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(4'h8, 32'h1);
        rd(4'h0, 32'h0);
        chk(64'(feature_ctrl), 64'h0);
        $display("second reset test done");
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule
